// [src/pad_defs.svh]
// Address map, field positions and timing counts for the processor address decoder.
`ifndef PAD_DEFS_SVH
`define PAD_DEFS_SVH

// Bus widths and size of each external space.
`define PAD_ADDR_W       16
`define PAD_DATA_W       8
`define PAD_SPACE_SIZE   65536

// Boundaries of the code space.
`define PAD_EPROM_TOP    16'h7FFF
`define PAD_CODE_RAM_LO  16'h8000

// Boundaries of the data space.
`define PAD_EEPROM_TOP   16'h7EFF
`define PAD_IO_PAGE      8'h7F
`define PAD_DATA_RAM_LO  16'h8000

// I/O window: bit 7 of the I/O address splits cardcage and front panel.
`define PAD_IO_HALF_BIT  7

// Address setup before a strobe, in ns, and the clock period in ns.
`define PAD_SETUP_NS     100
`define PAD_CLK_NS       100
`define PAD_SETUP_CYC    ((`PAD_SETUP_NS + `PAD_CLK_NS - 1) / `PAD_CLK_NS)

`endif

// [src/pad_pkg.sv]
// Types and the address decode function shared by the decoder modules.
`include "pad_defs.svh"

package pad_pkg;

	// Kind of processor bus cycle.
	typedef enum logic [1:0] {
		PAD_K_FETCH = 2'h0,
		PAD_K_READ  = 2'h1,
		PAD_K_WRITE = 2'h2
	} pad_kind_t;

	// Device selected by an address.
	typedef enum logic [2:0] {
		PAD_T_NONE   = 3'h0,
		PAD_T_EPROM  = 3'h1,
		PAD_T_EEPROM = 3'h2,
		PAD_T_RAM    = 3'h3,
		PAD_T_IO     = 3'h4
	} pad_target_t;

	// Access sequencer states.
	typedef enum logic [3:0] {
		PAD_S_IDLE  = 4'h1,
		PAD_S_SETUP = 4'h2,
		PAD_S_ACT   = 4'h4,
		PAD_S_HOLD  = 4'h8
	} pad_state_t;

	// Maps a cycle kind and address onto exactly one device.
	function automatic pad_target_t pad_decode(
		input pad_kind_t                kind,
		input logic [`PAD_ADDR_W-1:0]   addr,
		input logic                     merged
	);
		pad_target_t t;
		t = PAD_T_NONE;
		if (kind == PAD_K_FETCH)
		begin
			if (merged && addr >= `PAD_CODE_RAM_LO)
				t = PAD_T_RAM;
			else
				t = PAD_T_EPROM;
		end
		else if (addr <= `PAD_EEPROM_TOP)
			t = PAD_T_EEPROM;
		else if (addr[15:8] == `PAD_IO_PAGE)
			t = PAD_T_IO;
		else
			t = PAD_T_RAM;
		return t;
	endfunction : pad_decode

endpackage : pad_pkg

// [src/pad_sync.sv]
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps

module pad_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Asynchronous level in, synchronised level out.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : pad_sync

// [src/pad_iomap.sv]
// Splits the I/O window into write-only cardcage and read/write front panel.
`timescale 1ns/1ps
`include "pad_defs.svh"

module pad_iomap (
	// Access in the I/O window.
	input  wire logic [7:0] io_addr,
	input  wire logic       is_wr,
	input  wire logic       is_rd,
	// Strobes toward the two halves.
	output logic            cage_wr,
	output logic            panel_wr,
	output logic            panel_rd
);

	wire upper = io_addr[`PAD_IO_HALF_BIT];

	// Cardcage takes writes only; a read of the lower half reaches no one.
	assign cage_wr  = is_wr & ~upper;
	assign panel_wr = is_wr & upper;
	assign panel_rd = is_rd & upper;

endmodule : pad_iomap

// [src/pad_decoder.sv]
// Processor address decoder: memory selects and I/O bus bridge.
// How it works
// - Separate 64k code and data spaces, 16 lines.
// - Data space read/write; code space read only.
// - Strap input merges or separates upper halves.
// - Merged: fetch low half EPROM, upper RAM.
// - Separated: every fetch selects EPROM, never RAM.
// - Data 0000 to 7EFF selects EEPROM.
// - Data 8000 to FFFF selects RAM always.
// - I/O address is low byte of 7Fxx.
// - I/O data bit 0 LSB, bit 7 MSB.
// - Aliased I/O addresses act identically on ports.
// - Lower I/O half cardcage, write only.
// - Upper I/O half front panel, read/write.
`timescale 1ns/1ps
`include "pad_defs.svh"

module pad_decoder #(
	parameter int SETUP_CYC = `PAD_SETUP_CYC
) (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Processor bus pins, strobes active low.
	input  wire logic [`PAD_ADDR_W-1:0] proc_addr,
	input  wire logic                   proc_rd_n,
	input  wire logic                   proc_wr_n,
	input  wire logic                   proc_psen_n,
	input  wire logic [`PAD_DATA_W-1:0] proc_data_i,
	output logic      [`PAD_DATA_W-1:0] proc_data_o,
	output logic                        proc_data_oe,
	// Space configuration strap, high merges the upper halves.
	input  wire logic                   cfg_merged,
	// Memory selects and strobes, active high.
	output logic                        eprom_sel,
	output logic                        eeprom_sel,
	output logic                        ram_sel,
	output logic                        mem_oe,
	output logic                        mem_we,
	// I/O bus.
	output logic      [7:0]             io_addr,
	input  wire logic [7:0]             io_data_i,
	output logic      [7:0]             io_data_o,
	output logic                        io_data_oe,
	output logic                        io_sel,
	output logic                        cage_wr,
	output logic                        panel_wr,
	output logic                        panel_rd
);

	// Synchronised pin levels.
	logic [`PAD_ADDR_W-1:0] addr_s;
	logic [`PAD_DATA_W-1:0] pdata_s;
	logic [7:0]             iodata_s;
	logic                   rd_s;
	logic                   wr_s;
	logic                   fetch_s;
	logic                   merged_s;

	// Sequencer and latched access.
	pad_pkg::pad_state_t    state_q;
	pad_pkg::pad_state_t    state_d;
	pad_pkg::pad_kind_t     kind_q;
	pad_pkg::pad_target_t   tgt_q;
	logic [`PAD_ADDR_W-1:0] addr_q;
	logic [`PAD_DATA_W-1:0] wdata_q;
	logic [3:0]             cnt_q;
	logic [3:0]             cnt_d;

	// Output registers.
	logic                   eprom_sel_q;
	logic                   eeprom_sel_q;
	logic                   ram_sel_q;
	logic                   io_sel_q;
	logic                   mem_oe_q;
	logic                   mem_we_q;
	logic [7:0]             io_addr_q;
	logic [7:0]             io_data_o_q;
	logic                   io_data_oe_q;
	logic                   cage_wr_q;
	logic                   panel_wr_q;
	logic                   panel_rd_q;
	logic [`PAD_DATA_W-1:0] proc_data_o_q;
	logic                   proc_data_oe_q;

	// Pins cross into the clock domain; strobes are inverted so reset reads idle.
	pad_sync #(.W(`PAD_ADDR_W)) u_sync_addr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (proc_addr),
		.q       (addr_s)
	);

	pad_sync #(.W(`PAD_DATA_W)) u_sync_pdata (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (proc_data_i),
		.q       (pdata_s)
	);

	pad_sync #(.W(8)) u_sync_iodata (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (io_data_i),
		.q       (iodata_s)
	);

	pad_sync #(.W(4)) u_sync_ctl (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({~proc_rd_n, ~proc_wr_n, ~proc_psen_n, cfg_merged}),
		.q       ({rd_s, wr_s, fetch_s, merged_s})
	);

	// Exactly one strobe marks a legal cycle; overlapping strobes are ignored.
	wire one_strobe = (rd_s ^ wr_s ^ fetch_s) & ~(rd_s & wr_s & fetch_s);
	wire any_strobe = rd_s | wr_s | fetch_s;

	// Kind of the cycle now strobed.
	wire pad_pkg::pad_kind_t kind_now = fetch_s ? pad_pkg::PAD_K_FETCH :
		(wr_s ? pad_pkg::PAD_K_WRITE : pad_pkg::PAD_K_READ);

	// Strobe of the latched kind still held by the processor.
	wire same_strobe = (kind_q == pad_pkg::PAD_K_FETCH) ? fetch_s :
		((kind_q == pad_pkg::PAD_K_WRITE) ? wr_s : rd_s);

	// Decode of the synchronised address over the full 16-bit space.
	wire pad_pkg::pad_target_t tgt_now =
		pad_pkg::pad_decode(kind_now, addr_s, merged_s);

	// Latched access properties.
	wire is_fetch = (kind_q == pad_pkg::PAD_K_FETCH);
	wire is_write = (kind_q == pad_pkg::PAD_K_WRITE);
	wire is_read  = (kind_q == pad_pkg::PAD_K_READ);
	wire in_setup = (state_q == pad_pkg::PAD_S_SETUP);
	wire in_act   = (state_q == pad_pkg::PAD_S_ACT);
	wire live     = in_setup | in_act;

	// One-hot target; only one device can ever be chosen.
	wire t_eprom  = (tgt_q == pad_pkg::PAD_T_EPROM);
	wire t_eeprom = (tgt_q == pad_pkg::PAD_T_EEPROM);
	wire t_ram    = (tgt_q == pad_pkg::PAD_T_RAM);
	wire t_io     = (tgt_q == pad_pkg::PAD_T_IO);

	// I/O half strobes, decided only from the page offset.
	wire io_wr_now = in_act & t_io & is_write;
	wire io_rd_now = in_act & t_io & is_read;
	wire cage_wr_d;
	wire panel_wr_d;
	wire panel_rd_d;

	// Every aliased offset of a port yields the same strobe.
	pad_iomap u_iomap (
		.io_addr  (addr_q[7:0]),
		.is_wr    (io_wr_now),
		.is_rd    (io_rd_now),
		.cage_wr  (cage_wr_d),
		.panel_wr (panel_wr_d),
		.panel_rd (panel_rd_d)
	);

	// Next values of the memory selects and strobes.
	wire eprom_sel_d  = live & t_eprom;
	wire eeprom_sel_d = live & t_eeprom;
	wire ram_sel_d    = live & t_ram;
	wire io_sel_d     = live & t_io;
	wire mem_oe_d     = in_act & ~t_io & ~is_write;
	// A fetch never writes, so the code space has no write path.
	wire mem_we_d     = in_act & ~t_io & is_write & ~is_fetch;

	// I/O bus address is the low byte of a 7Fxx data address.
	wire [7:0] io_addr_d = t_io ? addr_q[7:0] : io_addr_q;

	// Write data drives the I/O bus bit for bit, bit 0 as LSB.
	wire       io_data_oe_d = live & t_io & is_write;
	wire [7:0] io_data_o_d  = wdata_q;

	// Only front panel reads return data; the cardcage has no read path.
	wire                   proc_data_oe_d = panel_rd_d;
	wire [`PAD_DATA_W-1:0] proc_data_o_d  = panel_rd_d ? iodata_s : proc_data_o_q;

	// Sequencer: latch, address setup, strobe while held, then hold until every strobe is released.
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			pad_pkg::PAD_S_IDLE:
			begin
				cnt_d = 4'h0;
				if (one_strobe)
					state_d = pad_pkg::PAD_S_SETUP;
			end
			pad_pkg::PAD_S_SETUP:
			begin
				cnt_d = cnt_q + 4'h1;
				if (!same_strobe)
					state_d = pad_pkg::PAD_S_HOLD;
				else if (cnt_q + 4'h1 >= 4'(SETUP_CYC))
					state_d = pad_pkg::PAD_S_ACT;
			end
			pad_pkg::PAD_S_ACT:
			begin
				if (!same_strobe)
					state_d = pad_pkg::PAD_S_HOLD;
			end
			pad_pkg::PAD_S_HOLD:
			begin
				if (!any_strobe)
					state_d = pad_pkg::PAD_S_IDLE;
			end
			default:
			begin
				state_d = pad_pkg::PAD_S_IDLE;
			end
		endcase
	end

	// State and counter registers.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= pad_pkg::PAD_S_IDLE;
			cnt_q   <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Access capture at the start of a cycle.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			kind_q  <= pad_pkg::PAD_K_READ;
			tgt_q   <= pad_pkg::PAD_T_NONE;
			addr_q  <= 16'h0000;
			wdata_q <= 8'h00;
		end
		else if (state_q == pad_pkg::PAD_S_IDLE && one_strobe)
		begin
			kind_q <= kind_now;
			tgt_q  <= tgt_now;
			addr_q <= addr_s;
		end
		else if (live && is_write)
			wdata_q <= pdata_s; // Follows the processor until its strobe ends.
	end

	// Memory select and strobe registers.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			eprom_sel_q  <= 1'b0;
			eeprom_sel_q <= 1'b0;
			ram_sel_q    <= 1'b0;
			io_sel_q     <= 1'b0;
			mem_oe_q     <= 1'b0;
			mem_we_q     <= 1'b0;
		end
		else
		begin
			eprom_sel_q  <= eprom_sel_d;
			eeprom_sel_q <= eeprom_sel_d;
			ram_sel_q    <= ram_sel_d;
			io_sel_q     <= io_sel_d;
			mem_oe_q     <= mem_oe_d;
			mem_we_q     <= mem_we_d;
		end
	end

	// I/O bus registers.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			io_addr_q    <= 8'h00;
			io_data_o_q  <= 8'h00;
			io_data_oe_q <= 1'b0;
			cage_wr_q    <= 1'b0;
			panel_wr_q   <= 1'b0;
			panel_rd_q   <= 1'b0;
		end
		else
		begin
			io_addr_q    <= io_addr_d;
			io_data_o_q  <= io_data_o_d;
			io_data_oe_q <= io_data_oe_d;
			cage_wr_q    <= cage_wr_d;
			panel_wr_q   <= panel_wr_d;
			panel_rd_q   <= panel_rd_d;
		end
	end

	// Read data back to the processor from the front panel.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			proc_data_o_q  <= 8'h00;
			proc_data_oe_q <= 1'b0;
		end
		else
		begin
			proc_data_o_q  <= proc_data_o_d;
			proc_data_oe_q <= proc_data_oe_d;
		end
	end

	// Outputs come straight from the registers.
	assign eprom_sel    = eprom_sel_q;
	assign eeprom_sel   = eeprom_sel_q;
	assign ram_sel      = ram_sel_q;
	assign io_sel       = io_sel_q;
	assign mem_oe       = mem_oe_q;
	assign mem_we       = mem_we_q;
	assign io_addr      = io_addr_q;
	assign io_data_o    = io_data_o_q;
	assign io_data_oe   = io_data_oe_q;
	assign cage_wr      = cage_wr_q;
	assign panel_wr     = panel_wr_q;
	assign panel_rd     = panel_rd_q;
	assign proc_data_o  = proc_data_o_q;
	assign proc_data_oe = proc_data_oe_q;

endmodule : pad_decoder

// [bench/pad_decoder_monitor.sv]
// Checker for the decoder's selects and I/O strobes.
`timescale 1ns/1ps

module pad_decoder_monitor (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        sys_rst,
	// Processor side.
	input wire logic [15:0] proc_addr,
	input wire logic        proc_rd_n,
	input wire logic        proc_wr_n,
	input wire logic        proc_psen_n,
	input wire logic        cfg_merged,
	input wire logic        proc_data_oe,
	// Device side.
	input wire logic        eprom_sel,
	input wire logic        eeprom_sel,
	input wire logic        ram_sel,
	input wire logic        io_sel,
	input wire logic        mem_we,
	input wire logic [7:0]  io_addr,
	input wire logic        cage_wr,
	input wire logic        panel_wr,
	input wire logic        panel_rd
);
	wire any_sel = eprom_sel | eeprom_sel | ram_sel | io_sel;

	// All checks run on the rising edge and rest during reset.
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sel_onehot_a: assert property ($onehot0({eprom_sel, eeprom_sel, ram_sel, io_sel}))
		else $error("Two selects high.");
	idle_clear_a: assert property ((proc_rd_n && proc_wr_n && proc_psen_n) [*6] |-> !any_sel)
		else $error("Select high with no strobe.");
	fetch_nowr_a: assert property (eprom_sel |-> !mem_we)
		else $error("Write toward code memory.");
	sep_fetch_a: assert property ((!proc_psen_n && !cfg_merged) [*6] |-> eprom_sel)
		else $error("Separated fetch missed code memory.");
	merge_fetch_a: assert property ((!proc_psen_n && cfg_merged && proc_addr[15]) [*6] |-> ram_sel)
		else $error("Merged upper fetch missed RAM.");
	eeprom_rng_a: assert property ($rose(eeprom_sel) |-> proc_addr <= 16'h7EFF && proc_psen_n)
		else $error("Nonvolatile select out of range.");
	io_window_a: assert property ($rose(io_sel) |-> proc_addr == {8'h7F, io_addr})
		else $error("I/O select or address wrong.");
	ram_rng_a: assert property ($rose(ram_sel) |-> proc_addr[15])
		else $error("RAM select below upper half.");
	cage_only_a: assert property (io_sel && !io_addr[7] |-> !proc_data_oe && !panel_rd && !panel_wr)
		else $error("Cardcage half read or panel strobed.");
	io_half_a: assert property (cage_wr || panel_rd || panel_wr |-> io_sel && io_addr[7] != cage_wr)
		else $error("I/O strobe in wrong half.");

	// Main scenarios reached.
	cov_cage_c: cover property (cage_wr);
	cov_panel_c: cover property (panel_rd);
	cov_merge_c: cover property (ram_sel && !proc_psen_n);
endmodule : pad_decoder_monitor

// [bench/pad_panel_model.sv]
// Front panel peripheral on the I/O bus, answering reads.
`timescale 1ns/1ps

module pad_panel_model (
	// Clock.
	input wire logic       clk,
	// I/O bus from the decoder.
	input wire logic       panel_rd,
	input wire logic [7:0] io_addr,
	// Read data back to the decoder.
	output logic     [7:0] io_data_i
);
	logic [7:0] junk_q = 8'h00;

	// Off the bus the lines show a pattern that moves every cycle.
	always @(posedge clk)
	begin
		junk_q <= junk_q + 8'h5B;
	end

	// A read returns the inverted address, bit 0 as the LSB.
	assign io_data_i = panel_rd ? ~io_addr : junk_q;
endmodule : pad_panel_model

// [bench/processor_address_decoder_tb.sv]
// Self-checking bench for the processor address decoder.
`timescale 1ns/1ps

module processor_address_decoder_tb;
	typedef struct packed {logic [1:0] k; logic [15:0] a; logic m; logic [3:0] sel;
		logic [4:0] stb;} pad_row_t;
	logic clk = 1'h0, sys_rst, proc_rd_n, proc_wr_n, proc_psen_n, cfg_merged;
	logic [15:0] proc_addr;
	logic [7:0] proc_data_i, proc_data_o, io_addr, io_data_i, io_data_o, wd_s;
	logic proc_data_oe, eprom_sel, eeprom_sel, ram_sel, mem_oe, mem_we, io_data_oe, io_sel;
	logic cage_wr, panel_wr, panel_rd;
	logic [3:0] sel_s;
	logic [4:0] stb_s;
	logic [1:0] oe_s;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	// Kind 0 fetch, 1 read, 2 write, 3 read and write together.
	pad_row_t rows [14] = '{
		'{2'h0, 16'h0000, 1'h1, 4'h8, 5'h10}, '{2'h0, 16'h7FFF, 1'h1, 4'h8, 5'h10},
		'{2'h0, 16'h8000, 1'h1, 4'h2, 5'h10}, '{2'h0, 16'h8000, 1'h0, 4'h8, 5'h10},
		'{2'h0, 16'hFFFF, 1'h0, 4'h8, 5'h10}, '{2'h1, 16'h7EFF, 1'h0, 4'h4, 5'h10},
		'{2'h2, 16'h0000, 1'h1, 4'h4, 5'h08}, '{2'h1, 16'h7F00, 1'h1, 4'h1, 5'h00},
		'{2'h2, 16'h7F7F, 1'h0, 4'h1, 5'h04}, '{2'h2, 16'h7F80, 1'h1, 4'h1, 5'h02},
		'{2'h1, 16'h7FFF, 1'h0, 4'h1, 5'h01}, '{2'h2, 16'h8000, 1'h0, 4'h2, 5'h08},
		'{2'h1, 16'hFFFF, 1'h1, 4'h2, 5'h10}, '{2'h3, 16'h8000, 1'h1, 4'h0, 5'h00}};

	pad_decoder uut (.clk(clk), .sys_rst(sys_rst), .proc_addr(proc_addr),
		.proc_rd_n(proc_rd_n), .proc_wr_n(proc_wr_n), .proc_psen_n(proc_psen_n),
		.proc_data_i(proc_data_i), .proc_data_o(proc_data_o), .proc_data_oe(proc_data_oe),
		.cfg_merged(cfg_merged), .eprom_sel(eprom_sel), .eeprom_sel(eeprom_sel),
		.ram_sel(ram_sel), .mem_oe(mem_oe), .mem_we(mem_we), .io_addr(io_addr),
		.io_data_i(io_data_i), .io_data_o(io_data_o), .io_data_oe(io_data_oe),
		.io_sel(io_sel), .cage_wr(cage_wr), .panel_wr(panel_wr), .panel_rd(panel_rd));
	pad_panel_model panel (.clk(clk), .panel_rd(panel_rd), .io_addr(io_addr),
		.io_data_i(io_data_i));

	// Clock and a ceiling on run time.
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			num_errors++;
			stop_test();
		end
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One bus cycle, held long enough for strobes, then released and drained.
	task automatic access(input logic [1:0] k, input logic [15:0] a, input logic m,
		input logic [7:0] d);
		cfg_merged = m;
		repeat (3) @(negedge clk);
		proc_addr = a;
		proc_data_i = d;
		proc_psen_n = (k != 2'h0);
		proc_rd_n = !k[0];
		proc_wr_n = !k[1];
		repeat (6) @(negedge clk);
		sel_s = {eprom_sel, eeprom_sel, ram_sel, io_sel};
		stb_s = {mem_oe, mem_we, cage_wr, panel_wr, panel_rd};
		wd_s = io_data_o;
		oe_s = {io_data_oe, proc_data_oe};
		{proc_psen_n, proc_rd_n, proc_wr_n} = 3'h7;
		repeat (6) @(negedge clk);
	endtask : access

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// Reset, table of accesses, then the awkward cases.
	initial
	begin
		sys_rst = 1'h1;
		{proc_psen_n, proc_rd_n, proc_wr_n} = 3'h7;
		cfg_merged = 1'h1;
		proc_addr = 16'h0000;
		proc_data_i = 8'h00;
		repeat (16) @(negedge clk);
		chk("reset", {4'h0, eprom_sel, eeprom_sel, ram_sel, io_sel}, 8'h00);
		sys_rst = 1'h0;
		foreach (rows[i])
		begin
			access(rows[i].k, rows[i].a, rows[i].m, 8'h5A);
			chk("selects", {4'h0, sel_s}, {4'h0, rows[i].sel});
			chk("strobes", {3'h0, stb_s}, {3'h0, rows[i].stb});
			chk("idle", {4'h0, eprom_sel, eeprom_sel, ram_sel, io_sel}, 8'h00);
			if (rows[i].sel == 4'h1)
				chk("io addr", io_addr, rows[i].a[7:0]);
		end
		access(2'h2, 16'h7F85, 1'h1, 8'hA5);
		chk("io data", wd_s, 8'hA5);
		chk("io write oe", {6'h00, oe_s}, 8'h02);
		access(2'h1, 16'h7FC3, 1'h1, 8'h00);
		chk("panel read", proc_data_o, 8'h3C);
		chk("panel read oe", {6'h00, oe_s}, 8'h01);
		chk("oe idle", {6'h00, io_data_oe, proc_data_oe}, 8'h00);
		for (int j = 0; j < 2; j++)
		begin
			access(2'h2, 16'h7F40 + 16'(j), 1'h1, 8'h11);
			chk("alias", {3'h0, stb_s}, 8'h04);
		end
		proc_addr = 16'h7EFF;
		proc_rd_n = 1'h0;
		repeat (6) @(negedge clk);
		sys_rst = 1'h1;
		repeat (2) @(negedge clk);
		chk("mid reset", {3'h0, eeprom_sel, mem_oe, io_sel, ram_sel, eprom_sel}, 8'h00);
		sys_rst = 1'h0;
		proc_rd_n = 1'h1;
		repeat (8) @(negedge clk);
		access(2'h1, 16'h7EFF, 1'h0, 8'h00);
		chk("after reset", {4'h0, sel_s}, 8'h04);
		chk("after reset stb", {3'h0, stb_s}, 8'h10);
		stop_test();
	end
endmodule : processor_address_decoder_tb

bind pad_decoder pad_decoder_monitor mon (.clk(clk), .sys_rst(sys_rst),
	.proc_addr(proc_addr), .proc_rd_n(proc_rd_n), .proc_wr_n(proc_wr_n),
	.proc_psen_n(proc_psen_n), .cfg_merged(cfg_merged), .proc_data_oe(proc_data_oe),
	.eprom_sel(eprom_sel), .eeprom_sel(eeprom_sel), .ram_sel(ram_sel), .io_sel(io_sel),
	.mem_we(mem_we), .io_addr(io_addr), .cage_wr(cage_wr), .panel_wr(panel_wr),
	.panel_rd(panel_rd));
